// ===== diag_frame_map.svh
`ifndef DIAG_FRAME_MAP_SVH
`define DIAG_FRAME_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFF_CTRL 5'h00
`define OFF_STATUS 5'h04
`define OFF_POST 5'h08
`define OFF_IRQ_STAT 5'h0c
`define OFF_IRQ_MASK 5'h10
`define OFF_STAT3 5'h14

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTRL_EXT_EN 0
`define CTRL_VAR96 1
`define CTRL_IRQ_BLK 2
`define CTRL_H_PRES 3
`define CTRL_MOD_END_LSB 8
`define CTRL_H_LEN_LSB 16
`define POST_CODE_LSB 0
`define POST_CHAN_LSB 8
`define POST_SLOT_LSB 16
`define POST_ALL_CH 24
`define POST_REMOVE 31
`define STAT3_OVF 7
`define EV_FULL 0
`define EV_BAD_CODE 1
`define EV_OVF 2
`define EV_DONE 3

// ---------------------------------------------------------------
// reset values and sizes
// ---------------------------------------------------------------
`define CTRL_RESET 32'h0000_0000
`define IRQ_MASK_RESET 4'h0
`define FRAME_MAX_BASIC 8'h40
`define FRAME_MAX_EXT 8'h60
`define IRQ_PART_LEN 8'h1d
`define ENTRY_BYTES 8'h03
`define HDR_SLOT_TAG 2'b10
`define CODE_RES_LO 5'h0a
`define CODE_RES_HI 5'h0f
`define CODE_RES_A 5'h1c
`define CODE_RES_B 5'h1f

`endif

// ===== diag_frame_pkg.sv
package diag_frame_pkg;

	typedef enum logic [4:0] {
		ERR_RESERVED = 5'h00,
		ERR_SHORT = 5'h01,
		ERR_UNDERVOLT = 5'h02,
		ERR_OVERVOLT = 5'h03,
		ERR_OVERLOAD = 5'h04,
		ERR_OVERTEMP = 5'h05,
		ERR_WIRE_BREAK = 5'h06,
		ERR_HIGH_LIMIT = 5'h07,
		ERR_LOW_LIMIT = 5'h08,
		ERR_FAULT = 5'h09,
		ERR_PARAM_CFG = 5'h10
	} err_code_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SCAN = 2'b01,
		ST_SEND = 2'b11,
		ST_DONE = 2'b10
	} fsm_t;

	typedef struct packed {
		logic valid;
		logic [5:0] slot;
		logic [5:0] chan;
		logic [4:0] code;
	} entry_t;

endpackage : diag_frame_pkg

// ===== diag_code_check.sv
`timescale 1ns/100ps
`include "diag_frame_map.svh"

module diag_code_check
	import diag_frame_pkg::*;
(
	input wire logic [4:0] code,
	output logic legal,
	output logic maker
);

	always_comb
	begin
		maker = (code >= ERR_PARAM_CFG);
		legal = (code != ERR_RESERVED);
		if ((code >= `CODE_RES_LO) && (code <= `CODE_RES_HI))
		begin
			legal = 1'b0;
		end
		if ((code == `CODE_RES_A) || (code == `CODE_RES_B))
		begin
			legal = 1'b0;
		end
	end

endmodule : diag_code_check

// ===== diag_budget.sv
`timescale 1ns/100ps
`include "diag_frame_map.svh"

module diag_budget
(
	input wire logic var96,
	input wire logic irq_blk,
	input wire logic [7:0] offset,
	output logic [7:0] budget
);

	logic [8:0] room;

	always_comb
	begin
		room = {1'b0, (var96 ? `FRAME_MAX_EXT : `FRAME_MAX_BASIC)} - {1'b0, offset};
		if (!irq_blk)
		begin
			room = room - {1'b0, `IRQ_PART_LEN};
		end
		budget = room[8] ? 8'h00 : room[7:0];
	end

endmodule : diag_budget

// ===== channel_diag_frame_builder.sv
// How it works
// - section follows module or redundancy status
// - module status never touched by entries
// - section only with extended diagnosis
// - frame capped at 64 or 96 bytes
// - section length follows active entry count
// - blocked interrupts free 29 more bytes
// - all-channel error goes to channel 0
// - overflow bit set when entries overflow
// - unsent entries kept for later frames
// - overflow bit cleared once backlog sent
// - codes 0 to 3 encoding
// - codes 4 to 6 encoding
// - codes 7 to 9, 10-15 reserved
// - third station status byte layout
// - maker codes from 16 upward
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "diag_frame_map.svh"

module channel_diag_frame_builder
	import diag_frame_pkg::*;
#(
	parameter int ENTRIES = 16
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic frame_req,
	output logic [7:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic frame_done,
	output logic [7:0] section_offset,
	output logic [7:0] section_len,
	output logic [7:0] stat3
);

	localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic ext_en;
		logic var96;
		logic irq_blk;
		logic h_pres;
		logic [7:0] mod_end;
		logic [7:0] h_len;
		logic [7:0] offset;
		entry_t [ENTRIES-1:0] tbl;
		logic [3:0] irq_st;
		logic [3:0] irq_mask;
		fsm_t st;
		logic [IW-1:0] idx;
		logic [1:0] bsel;
		logic [7:0] used;
		logic ovf_seen;
		logic ovf;
		logic [7:0] sec_len;
		logic [7:0] odata;
		logic done;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [4:0] byte_addr;
	logic [4:0] p_code;
	logic [5:0] p_slot;
	logic [5:0] p_chan;
	logic p_legal;
	logic [7:0] budget;
	logic [ENTRIES-1:0] match;
	logic [ENTRIES-1:0] free;

	assign byte_addr = {avs_address, 2'b00};
	assign p_code = avs_writedata[`POST_CODE_LSB +: 5];
	assign p_slot = avs_writedata[`POST_SLOT_LSB +: 6];
	assign p_chan = avs_writedata[`POST_ALL_CH] ? 6'h00 : avs_writedata[`POST_CHAN_LSB +: 6];

	diag_code_check u_code
	(
		.code(p_code),
		.legal(p_legal),
		.maker()
	);

	diag_budget u_budget
	(
		.var96(s_q.var96),
		.irq_blk(s_q.irq_blk),
		.offset(s_q.offset),
		.budget(budget)
	);

	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++)
		begin : g_ent
			assign match[gi] = s_q.tbl[gi].valid && (s_q.tbl[gi].slot == p_slot)
				&& (s_q.tbl[gi].chan == p_chan);
			assign free[gi] = !s_q.tbl[gi].valid;
		end
	endgenerate

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// three-byte record
	function automatic logic [7:0] entry_byte(input entry_t e, input logic [1:0] b);
		logic [7:0] r;
		r = {`HDR_SLOT_TAG, e.slot};
		if (b == 2'd1)
		begin
			r = {2'b00, e.chan};
		end
		else if (b == 2'd2)
		begin
			r = {3'b000, e.code};
		end
		return r;
	endfunction : entry_byte

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb
	begin
		logic [3:0] ev;
		logic we;
		logic hit;
		logic got_free;
		logic [IW-1:0] hit_i;
		logic [IW-1:0] free_i;
		logic [7:0] active;
		logic [31:0] rd;
		logic adv;
		entry_t e;
		ev = 4'h0;
		we = 1'b0;
		hit = 1'b0;
		got_free = 1'b0;
		hit_i = '0;
		free_i = '0;
		active = 8'h00;
		rd = 32'h0000_0000;
		adv = 1'b0;
		e = s_q.tbl[s_q.idx];
		s_d = s_q;
		s_d.done = 1'b0;

		// one wait cycle, then the request is taken
		s_d.ack = (avs_read || avs_write) && !s_q.ack;
		we = avs_write && s_q.ack;

		for (int i = ENTRIES - 1; i >= 0; i--)
		begin
			if (match[i])
			begin
				hit = 1'b1;
				hit_i = IW'(i);
			end
			if (free[i])
			begin
				got_free = 1'b1;
				free_i = IW'(i);
			end
			if (!free[i])
			begin
				active = active + 8'h01;
			end
		end

		s_d.offset = 8'(s_q.mod_end + (s_q.h_pres ? s_q.h_len : 8'h00));

		unique case (byte_addr)
			`OFF_CTRL:
			begin
				rd[`CTRL_EXT_EN] = s_q.ext_en;
				rd[`CTRL_VAR96] = s_q.var96;
				rd[`CTRL_IRQ_BLK] = s_q.irq_blk;
				rd[`CTRL_H_PRES] = s_q.h_pres;
				rd[`CTRL_MOD_END_LSB +: 8] = s_q.mod_end;
				rd[`CTRL_H_LEN_LSB +: 8] = s_q.h_len;
			end
			`OFF_STATUS:
			begin
				rd = {8'h00, active, s_q.sec_len, 6'h00, (s_q.st != ST_IDLE), s_q.ovf};
			end
			`OFF_IRQ_STAT:
			begin
				rd = {28'h0, s_q.irq_st};
			end
			`OFF_IRQ_MASK:
			begin
				rd = {28'h0, s_q.irq_mask};
			end
			`OFF_STAT3:
			begin
				rd = {24'h0, stat3};
			end
			default:
			begin
				rd = 32'h0000_0000;
			end
		endcase
		if (avs_read && !s_q.ack)
		begin
			s_d.rdata = rd;
		end

		if (we)
		begin
			unique case (byte_addr)
				`OFF_CTRL:
				begin
					s_d.ext_en = avs_writedata[`CTRL_EXT_EN];
					s_d.var96 = avs_writedata[`CTRL_VAR96];
					s_d.irq_blk = avs_writedata[`CTRL_IRQ_BLK];
					s_d.h_pres = avs_writedata[`CTRL_H_PRES];
					s_d.mod_end = avs_writedata[`CTRL_MOD_END_LSB +: 8];
					s_d.h_len = avs_writedata[`CTRL_H_LEN_LSB +: 8];
				end
				`OFF_POST:
				begin
					if (avs_writedata[`POST_REMOVE])
					begin
						if (hit)
						begin
							s_d.tbl[hit_i].valid = 1'b0;
						end
					end
					else if (!p_legal)
					begin
						ev[`EV_BAD_CODE] = 1'b1;
					end
					else if (hit)
					begin
						s_d.tbl[hit_i].code = p_code;
					end
					else if (got_free)
					begin
						s_d.tbl[free_i] = '{valid: 1'b1, slot: p_slot, chan: p_chan,
							code: p_code};
					end
					else
					begin
						ev[`EV_FULL] = 1'b1;
					end
				end
				`OFF_IRQ_MASK:
				begin
					s_d.irq_mask = avs_writedata[3:0];
				end
				default:
				begin
				end
			endcase
		end

		// ---------------------------------------------------------------
		// frame assembly
		// ---------------------------------------------------------------
		unique case (s_q.st)
			ST_IDLE:
			begin
				if (frame_req)
				begin
					s_d.used = 8'h00;
					s_d.idx = '0;
					s_d.ovf_seen = 1'b0;
					s_d.st = s_q.ext_en ? ST_SCAN : ST_DONE;
				end
			end
			ST_SCAN:
			begin
				adv = 1'b1;
				if (e.valid)
				begin
					if (({1'b0, s_q.used} + {1'b0, `ENTRY_BYTES}) <= {1'b0, budget})
					begin
						adv = 1'b0;
						s_d.bsel = 2'd0;
						s_d.odata = entry_byte(e, 2'd0);
						s_d.st = ST_SEND;
					end
					else
					begin
						s_d.ovf_seen = 1'b1;
					end
				end
			end
			ST_SEND:
			begin
				if (out_ready)
				begin
					s_d.used = s_q.used + 8'h01;
					if (s_q.bsel == 2'd2)
					begin
						adv = 1'b1;
					end
					else
					begin
						s_d.bsel = s_q.bsel + 2'd1;
						s_d.odata = entry_byte(e, s_q.bsel + 2'd1);
					end
				end
			end
			ST_DONE:
			begin
				s_d.ovf = s_q.ovf_seen;
				s_d.sec_len = s_q.used;
				s_d.done = 1'b1;
				ev[`EV_DONE] = 1'b1;
				ev[`EV_OVF] = s_q.ovf_seen && !s_q.ovf;
				s_d.st = ST_IDLE;
			end
			default:
			begin
				s_d.st = ST_IDLE;
			end
		endcase

		if (adv)
		begin
			s_d.st = ST_SCAN;
			if (s_q.idx == IW'(ENTRIES - 1))
			begin
				s_d.st = ST_DONE;
			end
			else
			begin
				s_d.idx = s_q.idx + IW'(1);
			end
		end

		// set wins over write-one-to-clear
		s_d.irq_st = s_q.irq_st;
		if (we && (byte_addr == `OFF_IRQ_STAT))
		begin
			s_d.irq_st = s_q.irq_st & ~avs_writedata[3:0];
		end
		s_d.irq_st = s_d.irq_st | ev;
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			s_q <= '0;
			s_q.ext_en <= 1'(`CTRL_RESET >> `CTRL_EXT_EN);
			s_q.irq_mask <= `IRQ_MASK_RESET;
			s_q.st <= ST_IDLE;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
	assign avs_readdata = s_q.rdata;
	assign irq = |(s_q.irq_st & s_q.irq_mask);
	assign out_valid = (s_q.st == ST_SEND);
	assign out_data = s_q.odata;
	assign frame_done = s_q.done;
	assign section_offset = s_q.offset;
	assign section_len = s_q.sec_len;
	assign stat3 = {s_q.ovf, 7'h00};

endmodule : channel_diag_frame_builder

// ===== diag_frame_sva.sv
`timescale 1ns/100ps
// ----
// frame builder port checks
// ----
module diag_frame_sva
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [7:0] out_data,
	input wire logic frame_done,
	input wire logic [7:0] section_offset,
	input wire logic [7:0] section_len,
	input wire logic [7:0] stat3
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_one_wait: assert property ($rose(avs_read || avs_write) |->
		avs_waitrequest ##1 !avs_waitrequest) else $error("wait state count wrong");
	chk_stat3_low: assert property (stat3[6:0] == 7'h00)
		else $error("stat3 low bits set");
	chk_len_triple: assert property (section_len % 3 == 0)
		else $error("section length not whole records");
	chk_frame_cap: assert property ({1'b0, section_offset} + {1'b0, section_len} <= 9'h060)
		else $error("frame exceeds limit");
	chk_done_pulse: assert property (frame_done |=> !frame_done)
		else $error("done longer than one cycle");
	chk_byte_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("byte dropped while stalled");
	chk_ovf_at_done: assert property ($changed(stat3) |-> frame_done)
		else $error("overflow moved outside build end");
	chk_len_at_done: assert property ($changed(section_len) |-> frame_done)
		else $error("length moved outside build end");
	cover property (frame_done && stat3[7]);
	cover property (out_valid && !out_ready);
	cover property (frame_done && section_len != 8'h00);
endmodule : diag_frame_sva

// ===== diag_sink.sv
`timescale 1ns/100ps
// ----
// reading master, stalls every other cycle when slow
// ----
module diag_sink
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic frame_req,
	input wire logic slow,
	input wire logic out_valid,
	input wire logic [7:0] out_data,
	output logic out_ready
);
	logic [7:0] b [16];
	int n = 0;
	logic tog = 1'b0;
	assign out_ready = !slow || tog;
	always @(posedge clk)
	begin
		tog <= ~tog;
		if (!reset_n || frame_req)
			n <= 0;
		else if (out_valid && out_ready && n < 16)
		begin
			b[n] <= out_data;
			n <= n + 1;
		end
	end
endmodule : diag_sink

// ===== test_channel_diag_frame_builder.sv
`timescale 1ns/100ps
module test_channel_diag_frame_builder;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic frame_req = 1'b0;
	logic slow = 1'b0;
	logic [2:0] avs_address = 3'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic [31:0] q;
	logic avs_waitrequest;
	logic irq;
	logic out_valid;
	logic out_ready;
	logic frame_done;
	logic [7:0] out_data;
	logic [7:0] section_offset;
	logic [7:0] section_len;
	logic [7:0] stat3;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [4:0] good [10] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h10};
	logic [4:0] bad [5] = '{5'h00, 5'h0a, 5'h0f, 5'h1c, 5'h1f};
	always #4 clk = ~clk;
	channel_diag_frame_builder #(.ENTRIES(4)) u_channel_diag_frame_builder (.clk, .reset_n,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.irq, .frame_req, .out_data, .out_valid, .out_ready, .frame_done, .section_offset,
		.section_len, .stat3);
	diag_sink u_diag_sink (.clk, .reset_n, .frame_req, .slow, .out_valid, .out_data, .out_ready);
	task automatic end_sim();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			end_sim();
		end
	end
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask : cmp
	// two trailing edges let registered outputs settle before a compare
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : bus
	task automatic post(input logic [7:0] f, input logic [5:0] s, c, input logic [4:0] k);
		bus(1'b1, 3'h2, {f, 2'b00, s, 2'b00, c, 3'b000, k});
	endtask : post
	task automatic build(input logic [7:0] len, input logic [7:0] st);
		frame_req <= 1'b1;
		@(posedge clk);
		frame_req <= 1'b0;
		do @(posedge clk); while (frame_done !== 1'b1);
		cmp(section_len, len);
		cmp(stat3, st);
	endtask : build
	task automatic rec(input int i, input logic [5:0] s, c, input logic [4:0] k);
		cmp({u_diag_sink.b[3*i], u_diag_sink.b[3*i+1], u_diag_sink.b[3*i+2]},
			{2'b10, s, 2'b00, c, 3'b000, k});
	endtask : rec
	initial
	begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, 3'h0, 32'h0);
		cmp(q, 32'h0);
		bus(1'b0, 3'h4, 32'h0);
		cmp(q, 32'h0);
		bus(1'b0, 3'h6, 32'h0);
		cmp(q, 32'h0);
		bus(1'b0, 3'h5, 32'h0);
		cmp(q, 32'h0);
		post(8'h00, 6'h01, 6'h01, 5'h01);
		build(8'h00, 8'h00);
		bus(1'b1, 3'h0, 32'h0005_0a09);
		cmp(section_offset, 8'h0f);
		bus(1'b1, 3'h0, 32'h0005_0a01);
		cmp(section_offset, 8'h0a);
		foreach (good[i])
		begin
			post(8'h00, 6'h03, 6'h02, good[i]);
			build(8'h06, 8'h00);
			rec(1, 6'h03, 6'h02, good[i]);
		end
		rec(0, 6'h01, 6'h01, 5'h01);
		bus(1'b1, 3'h4, 32'h2);
		foreach (bad[i])
		begin
			post(8'h00, 6'h03, 6'h02, bad[i]);
			cmp(irq, 1'b1);
			bus(1'b1, 3'h3, 32'h2);
			cmp(irq, 1'b0);
		end
		cmp(section_offset, 8'h0a);
		// 64 - 29 - 29 leaves two records
		bus(1'b1, 3'h0, 32'h0000_1d01);
		post(8'h01, 6'h04, 6'h05, 5'h06);
		slow <= 1'b1;
		build(8'h06, 8'h80);
		bus(1'b0, 3'h1, 32'h0);
		cmp(q[0], 1'b1);
		bus(1'b0, 3'h3, 32'h0);
		cmp(q[3:0], 4'hc);
		post(8'h80, 6'h01, 6'h01, 5'h01);
		build(8'h06, 8'h00);
		rec(0, 6'h03, 6'h02, 5'h10);
		rec(1, 6'h04, 6'h00, 5'h06);
		bus(1'b1, 3'h0, 32'h0000_3201);
		post(8'h00, 6'h01, 6'h01, 5'h02);
		build(8'h00, 8'h80);
		bus(1'b1, 3'h0, 32'h0000_3205);
		build(8'h09, 8'h00);
		post(8'h00, 6'h05, 6'h01, 5'h03);
		bus(1'b1, 3'h0, 32'h0000_3c03);
		build(8'h06, 8'h80);
		post(8'h00, 6'h06, 6'h01, 5'h03);
		bus(1'b0, 3'h3, 32'h0);
		cmp(q[0], 1'b1);
		end_sim();
	end
endmodule : test_channel_diag_frame_builder
bind channel_diag_frame_builder diag_frame_sva u_diag_frame_sva (.clk, .reset_n, .avs_read,
	.avs_write, .avs_waitrequest, .out_valid, .out_ready, .out_data, .frame_done,
	.section_offset, .section_len, .stat3);
